// *** hw/jsm_defs.vh ***
// Constants for the joystick speed mapping block
`ifndef JSM_DEFS_VH
`define JSM_DEFS_VH
// ==================================================
// Frame layout
`define JSM_CMD_READ 32'h796f6a67
`define JSM_CMD_WRITE 32'h796f6a73
`define JSM_CMD_LEN 5'h04
`define JSM_CMD_LAST 5'h03
`define JSM_FRAME_LAST 5'h15
`define JSM_OFS_LOWER 5'h04
`define JSM_OFS_CENTER 5'h06
`define JSM_OFS_UPPER 5'h08
`define JSM_OFS_CURVE 5'h0a
`define JSM_OFS_BAND 5'h0b
`define JSM_OFS_FLAGS 5'h0c
`define JSM_OFS_CRC 5'h14
`define JSM_FLAG_INVERT 0
`define JSM_POS_MAX 16'h2710
// ==================================================
// Reset values of the settings
`define JSM_RST_LOWER 16'h0000
`define JSM_RST_CENTER 16'h1388
`define JSM_RST_UPPER 16'h2710
// ==================================================
// Register map (word addresses)
`define JSM_ADDR_CTRL 4'ha
`define JSM_ADDR_STAT 4'hb
`define JSM_ADDR_SPEED 4'hc
`define JSM_CTRL_ENABLE 0
`define JSM_STAT_BUSY 4
`define JSM_STAT_STOP 5
`define JSM_TAB_FULL_MSB 16
`define JSM_TAB_USTEP_LSB 24
// ==================================================
// Arithmetic
`define JSM_Q_ONE 9'h100
`define JSM_DIV_STEPS 4'h8
`endif

// *** hw/jsm_speed_map.v ***
// Joystick to signed motor speed mapping with settings frame handling
// Functional notes
// - Settings read answer is 22 bytes: echo, positions, curve, band, flags, reserved, checksum.
// - Lower, centre and upper positions are unsigned 16-bit, at most 10000.
// - Inside the neutral band the speed is zero with a soft stop.
// - Outside the band speed scales from zero at band edge to full.
// - Beyond lower or upper limit the speed is plus or minus the table entry.
// - Table index starts at 0; left/right buttons step it.
// - A button step to an all-zero table entry is ignored.
// - Speed follows a curve whose bend is set by the nonlinearity factor.
// - Nonlinearity zero gives a linear deviation to speed relation.
// - Invert flag 0x01 makes higher samples give negative speed.
// - Settings read request is the read command code alone, 4 bytes.
// - Settings write request is the write code plus the answer layout.
// - Speed table holds ten entries of full steps and 1/256 microsteps.
`timescale 1ns/1ps
`default_nettype none
`include "jsm_defs.vh"

module jsm_speed_map #(
  parameter TABLE_LEN = 10
) (
  input wire i_clk,
  input wire i_nrst,
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_rx_valid,
  input wire [7:0] i_rx_byte,
  output wire o_rx_ready,
  output wire o_tx_valid,
  output reg [7:0] o_tx_byte,
  input wire i_tx_ready,
  input wire i_stick_valid,
  input wire [15:0] i_stick_sample,
  input wire i_btn_left,
  input wire i_btn_right,
  output reg signed [25:0] o_speed,
  output reg o_speed_valid,
  output reg o_soft_stop
);

  localparam ST_IDLE = 2'b00;
  localparam ST_DIV = 2'b01;
  localparam ST_APPLY = 2'b10;

  // ==================================================
  // Settings and speed table
  reg [15:0] lower_ff;
  reg [15:0] center_ff;
  reg [15:0] upper_ff;
  reg [7:0] curve_ff;
  reg [7:0] band_ff;
  reg [7:0] flags_ff;
  reg [24:0] tab_ff [0:TABLE_LEN-1];
  reg ctrl_en_ff;
  reg [3:0] idx_ff;
  integer i;
  integer j;

  function [24:0] entry_total;
    input [3:0] n;
    reg [24:0] e;
    begin
      e = tab_ff[n];
      entry_total = {e[`JSM_TAB_FULL_MSB:0], e[24:17]};
    end
  endfunction

  // ==================================================
  // Frame receive and transmit
  reg [7:0] rx_mem_ff [0:`JSM_FRAME_LAST];
  reg [4:0] rx_cnt_ff;
  reg rx_wr_ff;
  reg tx_busy_ff;
  reg [4:0] tx_cnt_ff;
  reg [4:0] tx_last_ff;
  reg [31:0] tx_cmd_ff;

  function [7:0] frame_byte;
    input [4:0] idx;
    input [31:0] cmd;
    reg [15:0] sum;
    integer k;
    begin
      sum = 16'h0000;
      for (k = 0; k < `JSM_OFS_CRC; k = k + 1) begin
        sum = sum + {8'h00, frame_byte_plain(k[4:0], cmd)};
      end
      frame_byte = (idx < `JSM_OFS_CRC) ? frame_byte_plain(idx, cmd) :
                   (idx == `JSM_OFS_CRC) ? sum[7:0] : sum[15:8];
    end
  endfunction

  // Same as frame_byte without the checksum, to keep the sum loop non-recursive
  function [7:0] frame_byte_plain;
    input [4:0] idx;
    input [31:0] cmd;
    begin
      case (idx)
        `JSM_OFS_LOWER: frame_byte_plain = lower_ff[7:0];
        `JSM_OFS_LOWER + 5'h01: frame_byte_plain = lower_ff[15:8];
        `JSM_OFS_CENTER: frame_byte_plain = center_ff[7:0];
        `JSM_OFS_CENTER + 5'h01: frame_byte_plain = center_ff[15:8];
        `JSM_OFS_UPPER: frame_byte_plain = upper_ff[7:0];
        `JSM_OFS_UPPER + 5'h01: frame_byte_plain = upper_ff[15:8];
        `JSM_OFS_CURVE: frame_byte_plain = curve_ff;
        `JSM_OFS_BAND: frame_byte_plain = band_ff;
        `JSM_OFS_FLAGS: frame_byte_plain = flags_ff;
        default: frame_byte_plain = (idx < `JSM_CMD_LEN) ? cmd[{idx[1:0], 3'b000} +: 8] : 8'h00;
      endcase
    end
  endfunction

  reg [15:0] rx_sum;
  integer k2;
  always @* begin
    rx_sum = 16'h0000;
    for (k2 = 0; k2 < `JSM_OFS_CRC; k2 = k2 + 1) begin
      rx_sum = rx_sum + {8'h00, rx_mem_ff[k2]};
    end
  end

  // Receive is held off while an answer is going out, so settings never change mid-answer
  assign o_rx_ready = ~tx_busy_ff;
  assign o_tx_valid = tx_busy_ff;

  wire rx_take = i_rx_valid & ~tx_busy_ff;
  wire [31:0] rx_cmd = {i_rx_byte, rx_mem_ff[2], rx_mem_ff[1], rx_mem_ff[0]};
  wire [15:0] rx_lower = {rx_mem_ff[`JSM_OFS_LOWER + 5'h01], rx_mem_ff[`JSM_OFS_LOWER]};
  wire [15:0] rx_center = {rx_mem_ff[`JSM_OFS_CENTER + 5'h01], rx_mem_ff[`JSM_OFS_CENTER]};
  wire [15:0] rx_upper = {rx_mem_ff[`JSM_OFS_UPPER + 5'h01], rx_mem_ff[`JSM_OFS_UPPER]};
  wire rx_crc_ok = ({i_rx_byte, rx_mem_ff[`JSM_OFS_CRC]} == rx_sum);
  wire rx_range_ok = (rx_lower <= `JSM_POS_MAX) && (rx_center <= `JSM_POS_MAX) &&
                     (rx_upper <= `JSM_POS_MAX);
  wire rx_apply = rx_take && rx_wr_ff && (rx_cnt_ff == `JSM_FRAME_LAST) && rx_crc_ok &&
                  rx_range_ok;
  wire tx_take = tx_busy_ff & i_tx_ready;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_cnt_ff <= 5'h00;
      rx_wr_ff <= 1'b0;
      tx_busy_ff <= 1'b0;
      tx_cnt_ff <= 5'h00;
      tx_last_ff <= 5'h00;
      tx_cmd_ff <= 32'h00000000;
      o_tx_byte <= 8'h00;
      for (i = 0; i <= `JSM_FRAME_LAST; i = i + 1) begin
        rx_mem_ff[i] <= 8'h00;
      end
    end else begin
      if (rx_take) begin
        rx_mem_ff[rx_cnt_ff] <= i_rx_byte;
        rx_cnt_ff <= rx_cnt_ff + 5'h01;
        if (rx_cnt_ff == `JSM_CMD_LAST && !rx_wr_ff) begin
          if (rx_cmd == `JSM_CMD_READ) begin
            rx_cnt_ff <= 5'h00;
            tx_busy_ff <= 1'b1;
            tx_cnt_ff <= 5'h00;
            tx_last_ff <= `JSM_FRAME_LAST;
            tx_cmd_ff <= `JSM_CMD_READ;
            o_tx_byte <= frame_byte(5'h00, `JSM_CMD_READ);
          end else if (rx_cmd == `JSM_CMD_WRITE) begin
            rx_wr_ff <= 1'b1;
          end else begin
            rx_cnt_ff <= 5'h00;
          end
        end else if (rx_cnt_ff == `JSM_FRAME_LAST) begin
          rx_cnt_ff <= 5'h00;
          rx_wr_ff <= 1'b0;
          if (rx_apply) begin
            tx_busy_ff <= 1'b1;
            tx_cnt_ff <= 5'h00;
            tx_last_ff <= `JSM_CMD_LAST;
            tx_cmd_ff <= `JSM_CMD_WRITE;
            o_tx_byte <= frame_byte(5'h00, `JSM_CMD_WRITE);
          end
        end
      end
      if (tx_take) begin
        if (tx_cnt_ff == tx_last_ff) begin
          tx_busy_ff <= 1'b0;
        end else begin
          tx_cnt_ff <= tx_cnt_ff + 5'h01;
          o_tx_byte <= frame_byte(tx_cnt_ff + 5'h01, tx_cmd_ff);
        end
      end
    end
  end

  // ==================================================
  // Buttons: three-stage synchroniser, change taken when stages two and three agree
  reg [2:0] lsync_ff;
  reg [2:0] rsync_ff;
  reg lbtn_ff;
  reg rbtn_ff;
  wire lbtn_nxt = (lsync_ff[1] == lsync_ff[2]) ? lsync_ff[2] : lbtn_ff;
  wire rbtn_nxt = (rsync_ff[1] == rsync_ff[2]) ? rsync_ff[2] : rbtn_ff;
  wire lpress = lbtn_nxt & ~lbtn_ff;
  wire rpress = rbtn_nxt & ~rbtn_ff;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lsync_ff <= 3'h0;
      rsync_ff <= 3'h0;
      lbtn_ff <= 1'b0;
      rbtn_ff <= 1'b0;
    end else begin
      lsync_ff <= {lsync_ff[1:0], i_btn_left};
      rsync_ff <= {rsync_ff[1:0], i_btn_right};
      lbtn_ff <= lbtn_nxt;
      rbtn_ff <= rbtn_nxt;
    end
  end

  // ==================================================
  // Settings, table and index storage
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lower_ff <= `JSM_RST_LOWER;
      center_ff <= `JSM_RST_CENTER;
      upper_ff <= `JSM_RST_UPPER;
      curve_ff <= 8'h00;
      band_ff <= 8'h00;
      flags_ff <= 8'h00;
      ctrl_en_ff <= 1'b0;
      idx_ff <= 4'h0;
      for (j = 0; j < TABLE_LEN; j = j + 1) begin
        tab_ff[j] <= 25'h0000000;
      end
    end else begin
      if (rx_apply) begin
        lower_ff <= rx_lower;
        center_ff <= rx_center;
        upper_ff <= rx_upper;
        curve_ff <= rx_mem_ff[`JSM_OFS_CURVE];
        band_ff <= rx_mem_ff[`JSM_OFS_BAND];
        flags_ff <= rx_mem_ff[`JSM_OFS_FLAGS];
      end
      if (i_wr && i_addr < TABLE_LEN) begin
        tab_ff[i_addr] <= {i_wdata[`JSM_TAB_USTEP_LSB +: 8], i_wdata[`JSM_TAB_FULL_MSB:0]};
      end
      if (i_wr && i_addr == `JSM_ADDR_CTRL) begin
        ctrl_en_ff <= i_wdata[`JSM_CTRL_ENABLE];
      end
      // Left wins if both buttons are pressed in one cycle
      if (lpress) begin
        if (idx_ff != 4'h0 && entry_total(idx_ff - 4'h1) != 25'h0000000) begin
          idx_ff <= idx_ff - 4'h1;
        end
      end else if (rpress) begin
        if (idx_ff < TABLE_LEN - 1 && entry_total(idx_ff + 4'h1) != 25'h0000000) begin
          idx_ff <= idx_ff + 4'h1;
        end
      end
    end
  end

  // ==================================================
  // Speed computation
  reg [1:0] st_ff;
  reg pos_ff;
  reg [16:0] rem_ff;
  reg [15:0] den_ff;
  reg [7:0] q_ff;
  reg [3:0] div_cnt_ff;
  reg [8:0] frac_ff;

  wire pos_side = (i_stick_sample >= center_ff);
  wire [15:0] dev = pos_side ? i_stick_sample - center_ff : center_ff - i_stick_sample;
  wire [15:0] span = pos_side ? upper_ff - center_ff : center_ff - lower_ff;
  wire [15:0] band16 = {8'h00, band_ff};
  wire [16:0] rem_sh = {rem_ff[15:0], 1'b0};
  wire rem_ge = (rem_sh >= {1'b0, den_ff});
  // Bend below the straight line: frac - k*frac*(1-frac), zero at both ends
  wire [15:0] parab = frac_ff * (`JSM_Q_ONE - frac_ff);
  wire [23:0] bend = parab * curve_ff;
  wire [8:0] shaped = frac_ff - {1'b0, bend[23:16]};
  wire [33:0] prod = entry_total(idx_ff) * shaped;
  wire [25:0] mag = prod[33:8];
  wire neg = (pos_ff == flags_ff[`JSM_FLAG_INVERT]);

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff <= ST_IDLE;
      pos_ff <= 1'b0;
      rem_ff <= 17'h00000;
      den_ff <= 16'h0000;
      q_ff <= 8'h00;
      div_cnt_ff <= 4'h0;
      frac_ff <= 9'h000;
      o_speed <= 26'sh0000000;
      o_speed_valid <= 1'b0;
      o_soft_stop <= 1'b1;
    end else begin
      o_speed_valid <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          if (i_stick_valid && ctrl_en_ff) begin
            pos_ff <= pos_side;
            if (dev <= band16) begin
              frac_ff <= 9'h000;
              st_ff <= ST_APPLY;
            end else if (dev >= span) begin
              frac_ff <= `JSM_Q_ONE;
              st_ff <= ST_APPLY;
            end else begin
              rem_ff <= {1'b0, dev - band16};
              den_ff <= span - band16;
              q_ff <= 8'h00;
              div_cnt_ff <= 4'h0;
              st_ff <= ST_DIV;
            end
          end
        end
        ST_DIV: begin
          rem_ff <= rem_ge ? rem_sh - {1'b0, den_ff} : rem_sh;
          q_ff <= {q_ff[6:0], rem_ge};
          div_cnt_ff <= div_cnt_ff + 4'h1;
          if (div_cnt_ff == `JSM_DIV_STEPS - 4'h1) begin
            frac_ff <= {1'b0, q_ff[6:0], rem_ge};
            st_ff <= ST_APPLY;
          end
        end
        ST_APPLY: begin
          o_speed <= neg ? -$signed(mag) : $signed(mag);
          o_soft_stop <= (frac_ff == 9'h000);
          o_speed_valid <= 1'b1;
          st_ff <= ST_IDLE;
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // ==================================================
  // Register read port
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      o_rdata <= 32'h00000000;
      if (i_addr < TABLE_LEN) begin
        o_rdata[`JSM_TAB_FULL_MSB:0] <= tab_ff[i_addr][`JSM_TAB_FULL_MSB:0];
        o_rdata[`JSM_TAB_USTEP_LSB +: 8] <= tab_ff[i_addr][24:17];
      end else if (i_addr == `JSM_ADDR_CTRL) begin
        o_rdata[`JSM_CTRL_ENABLE] <= ctrl_en_ff;
      end else if (i_addr == `JSM_ADDR_STAT) begin
        o_rdata[3:0] <= idx_ff;
        o_rdata[`JSM_STAT_BUSY] <= (st_ff != ST_IDLE);
        o_rdata[`JSM_STAT_STOP] <= o_soft_stop;
      end else if (i_addr == `JSM_ADDR_SPEED) begin
        o_rdata <= {{6{o_speed[25]}}, o_speed};
      end
    end
  end

endmodule // jsm_speed_map
`default_nettype wire

// *** sim/jsm_speed_map_asserts.sv ***
// Port checker for the joystick speed mapping block
`timescale 1ns/1ps
`default_nettype none
module jsm_speed_map_asserts (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_rx_valid,
  input wire logic o_rx_ready,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_byte,
  input wire logic i_tx_ready,
  input wire logic i_stick_valid,
  input wire logic signed [25:0] o_speed,
  input wire logic o_speed_valid,
  input wire logic o_soft_stop
);
  // ==================================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_byte_taken;
    i_rx_valid && o_rx_ready;
  endsequence
  sequence s_byte_stalled;
    o_tx_valid && !i_tx_ready;
  endsequence
  property p_rx_block;
    o_tx_valid |-> !o_rx_ready;
  endproperty
  property p_tx_hold;
    s_byte_stalled |=> o_tx_valid && $stable(o_tx_byte);
  endproperty
  property p_answer_start;
    $rose(o_tx_valid) |-> $past(i_rx_valid && o_rx_ready);
  endproperty
  property p_valid_pulse;
    o_speed_valid |=> !o_speed_valid;
  endproperty
  property p_stop_zero;
    o_speed_valid && o_soft_stop |-> o_speed == 26'sd0;
  endproperty
  property p_stop_on_update;
    $changed(o_soft_stop) |-> o_speed_valid;
  endproperty
  property p_speed_hold;
    !o_speed_valid |-> $stable(o_speed);
  endproperty
  // Update lands 2 cycles after a band or limit case, 10 after a divide
  property p_latency;
    o_speed_valid |-> $past(i_stick_valid, 2) || $past(i_stick_valid, 10);
  endproperty
  // ==================================================
  // Assertions
  a_rx_block: assert property (p_rx_block) else $error("rx ready while answering");
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte changed while stalled");
  a_answer_start: assert property (p_answer_start) else $error("answer not after byte");
  a_valid_pulse: assert property (p_valid_pulse) else $error("speed valid too long");
  a_stop_zero: assert property (p_stop_zero) else $error("nonzero speed in band");
  a_stop_on_update: assert property (p_stop_on_update) else $error("stop moved alone");
  a_speed_hold: assert property (p_speed_hold) else $error("speed moved alone");
  a_latency: assert property (p_latency) else $error("speed update latency");
  c_answer: cover property (s_byte_taken ##1 $rose(o_tx_valid));
endmodule // jsm_speed_map_asserts
bind jsm_speed_map jsm_speed_map_asserts jsm_speed_map_asserts_inst (.i_clk(i_clk),
  .i_nrst(i_nrst), .i_rx_valid(i_rx_valid), .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid),
  .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready), .i_stick_valid(i_stick_valid),
  .o_speed(o_speed), .o_speed_valid(o_speed_valid), .o_soft_stop(o_soft_stop));
`default_nettype wire

// *** sim/jsm_host_model.sv ***
// Host side model: sends settings frames, collects answer bytes
`timescale 1ns/1ps
`default_nettype none
module jsm_host_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_slow,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  input wire logic i_rx_ready,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  output logic o_tx_ready
);
  logic [7:0] ans [0:255];
  logic [7:0] frm [0:21];
  int n_ans;
  logic toggle;
  // ==================================================
  // Answer collection, slow mode stalls every other cycle
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      n_ans <= 0;
      toggle <= 1'b0;
    end else begin
      toggle <= ~toggle;
      if (i_tx_valid && o_tx_ready) begin
        ans[n_ans[7:0]] <= i_tx_byte;
        n_ans <= n_ans + 1;
      end
    end
  end
  assign o_tx_ready = !i_slow || toggle;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
  end
  // ==================================================
  // Whole frame, each byte held until the edge that takes it
  task automatic send(input int len);
    @(posedge i_clk);
    for (int i = 0; i < len; i++) begin
      o_rx_valid <= 1'b1;
      o_rx_byte <= frm[i];
      do @(negedge i_clk); while (!i_rx_ready);
      @(posedge i_clk);
    end
    o_rx_valid <= 1'b0;
    // Released line shows the inverse so no stale byte looks valid
    o_rx_byte <= ~frm[len-1];
  endtask
endmodule // jsm_host_model
`default_nettype wire

// *** sim/joystick_speed_mapping_tb.sv ***
// Self-checking testbench for the joystick speed mapping block
`timescale 1ns/1ps
`default_nettype none
`include "jsm_defs.vh"
module joystick_speed_mapping_tb;
  logic i_clk, i_nrst, i_wr, i_rd, i_stick_valid, i_btn_left, i_btn_right, slow;
  logic [3:0] i_addr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [15:0] i_stick_sample;
  logic rx_valid, rx_ready, tx_valid, tx_ready, o_speed_valid, o_soft_stop;
  logic [7:0] rx_byte, tx_byte;
  logic signed [25:0] o_speed;
  int n_mismatch, num_checks, base;
  jsm_speed_map jsm_speed_map_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_valid(rx_valid),
    .i_rx_byte(rx_byte), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte),
    .i_tx_ready(tx_ready), .i_stick_valid(i_stick_valid), .i_stick_sample(i_stick_sample),
    .i_btn_left(i_btn_left), .i_btn_right(i_btn_right), .o_speed(o_speed),
    .o_speed_valid(o_speed_valid), .o_soft_stop(o_soft_stop));
  jsm_host_model jsm_host_model_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_slow(slow),
    .o_rx_valid(rx_valid), .o_rx_byte(rx_byte), .i_rx_ready(rx_ready),
    .i_tx_valid(tx_valid), .i_tx_byte(tx_byte), .o_tx_ready(tx_ready));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // ==================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask
  // Builds the frame; for a read only the command goes out, the rest is the expected answer
  task automatic frame(input logic [31:0] cmd, input logic [15:0] lo, input logic [15:0] ce,
      input logic [15:0] up, input logic [7:0] cv, input logic [7:0] bd, input logic [7:0] fl,
      input bit bad, input int len, input int n_exp);
    logic [103:0] v;
    logic [15:0] sum;
    v = {fl, bd, cv, up, ce, lo, cmd};
    sum = 16'h0000;
    for (int i = 0; i < 20; i++) begin
      jsm_host_model_inst.frm[i] = (i < 13) ? v[8*i +: 8] : 8'h00;
      sum = sum + ((i < 13) ? v[8*i +: 8] : 8'h00);
    end
    jsm_host_model_inst.frm[20] = sum[7:0] ^ {7'h00, bad};
    jsm_host_model_inst.frm[21] = sum[15:8];
    base = jsm_host_model_inst.n_ans;
    jsm_host_model_inst.send(len);
    for (int i = 0; i < 200 && jsm_host_model_inst.n_ans < base + n_exp; i++) @(negedge i_clk);
    repeat (30) @(negedge i_clk);
    chk(jsm_host_model_inst.n_ans - base, n_exp, "answer length");
    for (int i = 0; i < n_exp; i++)
      chk(jsm_host_model_inst.ans[base + i], jsm_host_model_inst.frm[i], "answer byte");
  endtask
  task automatic samp(input logic [15:0] s, input logic [31:0] exp, input logic stop);
    int i;
    @(posedge i_clk);
    i_stick_valid <= 1'b1;
    i_stick_sample <= s;
    @(posedge i_clk);
    i_stick_valid <= 1'b0;
    i = 0;
    do begin
      @(negedge i_clk);
      i++;
    end while (o_speed_valid !== 1'b1 && i < 20);
    chk(o_speed_valid, 1'b1, "speed update");
    chk(o_speed, exp, "speed");
    chk(o_soft_stop, stop, "soft stop");
  endtask
  task automatic press(input bit left, input logic [3:0] idx);
    @(posedge i_clk);
    i_btn_left <= left;
    i_btn_right <= !left;
    repeat (8) @(posedge i_clk);
    i_btn_left <= 1'b0;
    i_btn_right <= 1'b0;
    repeat (8) @(posedge i_clk);
    rd(`JSM_ADDR_STAT);
    chk(d[3:0], idx, "table index");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==================================================
  // Scenarios
  initial begin
    {i_nrst, i_wr, i_rd, i_stick_valid, i_btn_left, i_btn_right} = 6'h00;
    {i_addr, i_wdata, i_stick_sample} = 52'h0;
    slow = 1'b1;
    n_mismatch = 0;
    num_checks = 0;
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    chk(o_soft_stop, 1'b1, "reset stop");
    rd(`JSM_ADDR_STAT);
    chk(d, 32'h00000020, "reset status");
    rd(4'he);
    chk(d, 32'h00000000, "unmapped read");
    frame(`JSM_CMD_READ, 16'h0000, 16'h1388, 16'h2710, 8'h00, 8'h00, 8'h00, 0, 4, 22);
    $display("test frames slow done");
    slow <= 1'b0;
    frame(`JSM_CMD_WRITE, 16'h03e8, 16'h1388, 16'h2328, 8'h00, 8'h64, 8'h00, 0, 22, 4);
    frame(`JSM_CMD_WRITE, 16'h03e8, 16'h1388, 16'h251c, 8'h00, 8'h64, 8'h00, 1, 22, 0);
    frame(`JSM_CMD_WRITE, 16'h03e8, 16'h1388, 16'h2711, 8'h00, 8'h64, 8'h00, 0, 22, 0);
    frame(`JSM_CMD_READ, 16'h03e8, 16'h1388, 16'h2328, 8'h00, 8'h64, 8'h00, 0, 4, 22);
    $display("test frames done");
    wr(4'h0, 32'h00000064);
    wr(`JSM_ADDR_CTRL, 32'h00000001);
    rd(`JSM_ADDR_CTRL);
    chk(d, 32'h00000001, "control readback");
    samp(16'd5050, 32'h0, 1'b1);
    samp(16'd9500, 32'd25600, 1'b0);
    samp(16'd500, -32'd25600, 1'b0);
    samp(16'd7100, 32'd13100, 1'b0);
    frame(`JSM_CMD_WRITE, 16'h03e8, 16'h1388, 16'h2328, 8'hff, 8'h64, 8'h00, 0, 22, 4);
    samp(16'd7100, 32'd6800, 1'b0);
    frame(`JSM_CMD_WRITE, 16'h03e8, 16'h1388, 16'h2328, 8'h00, 8'h64, 8'h01, 0, 22, 4);
    samp(16'd9500, -32'd25600, 1'b0);
    $display("test speed done");
    press(1'b0, 4'h0);
    wr(4'h1, 32'h80000000);
    rd(4'h1);
    chk(d, 32'h80000000, "table word");
    press(1'b0, 4'h1);
    samp(16'd9500, -32'd128, 1'b0);
    rd(`JSM_ADDR_SPEED);
    chk(d, 32'hffffff80, "speed register");
    press(1'b0, 4'h1);
    press(1'b1, 4'h0);
    $display("test buttons done");
    stop_test;
  end
  // Whole run needs well under 10000 cycles
  initial begin
    #(8 * 40000);
    n_mismatch++;
    stop_test;
  end
endmodule // joystick_speed_mapping_tb
`default_nettype wire
